// ==== design/sse_pkg.sv ====
// shared constants, layouts and carriers for the standby/suspend event selector
package sse_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFS_TRIG_0 = 8'h32;
    localparam logic [7:0] OFS_TRIG_1 = 8'h33;
    localparam logic [7:0] OFS_TRIG_2 = 8'h34;
    localparam logic [7:0] OFS_TRIG_3 = 8'h35;
    localparam logic [7:0] OFS_BRK_0 = 8'h37;
    localparam logic [7:0] OFS_BRK_1 = 8'h38;
    localparam logic [7:0] OFS_BRK_2 = 8'h39;
    localparam logic [7:0] OFS_BRK_3 = 8'h3a;
    localparam logic [7:0] OFS_EXT_SMI = 8'h3c;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h3d;
    localparam logic [7:0] OFS_SW_SMI = 8'h3e;
    localparam logic [7:0] OFS_SUSP_CTL0 = 8'h40;

    // reset value and writable bits
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] WMASK_SRC_1 = 8'h7f;
    localparam logic [7:0] WMASK_EXT_SMI = 8'h77;
    localparam logic [7:0] WMASK_SW_SMI = 8'h01;

    // field positions
    localparam int EXT_POL_LSB = 4;
    localparam int EXT_EN_LSB = 0;
    localparam int SW_SMI_BIT = 0;
    localparam int SC_VM_X16 = 7;
    localparam int SC_SYS_X16 = 6;
    localparam int SC_VM_BREAK = 5;
    localparam int SC_VM_BYPASS = 4;
    localparam int SC_BREAK_SMI = 3;
    localparam int SC_BATLOW = 2;

    // legacy i/o windows: base and span
    localparam logic [15:0] IO_278 = 16'h0278;
    localparam logic [15:0] IO_240 = 16'h0240;
    localparam logic [15:0] IO_220 = 16'h0220;
    localparam logic [15:0] IO_1F0 = 16'h01f0;
    localparam logic [15:0] IO_170 = 16'h0170;
    localparam logic [15:0] IO_3F8 = 16'h03f8;
    localparam logic [15:0] IO_3E8 = 16'h03e8;
    localparam logic [15:0] IO_3BC = 16'h03bc;
    localparam logic [15:0] IO_388 = 16'h0388;
    localparam logic [15:0] IO_378 = 16'h0378;
    localparam logic [15:0] IO_300 = 16'h0300;
    localparam logic [15:0] IO_2F8 = 16'h02f8;
    localparam logic [15:0] IO_2E8 = 16'h02e8;
    localparam logic [15:0] SPAN_4 = 16'h0004;
    localparam logic [15:0] SPAN_8 = 16'h0008;
    localparam logic [15:0] SPAN_16 = 16'h0010;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sse_reg_req_t;

    // everything that arrives from outside the clock domain
    typedef struct packed {
        logic [15:0] irq;
        logic ext_act;
        logic pci_req;
        logic [3:0] gcs;
        logic [2:0] ext_smi;
        logic bat_low_n;
        logic io_rd;
        logic io_wr;
        logic [15:0] io_addr;
    } sse_pins_t;

    // why the smi pulse fired
    typedef struct packed {
        logic [2:0] ext;
        logic sw;
        logic gs_break;
        logic as_break;
    } sse_smi_cause_t;

    // address falls inside an aligned window of power-of-two span
    function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base,
                                       input logic [15:0] span);
        in_window = (addr & ~(span - 16'h0001)) == base;
    endfunction
endpackage

// ==== design/sse_event_select.sv ====
// standby/suspend event selection, external and software smi, auto-suspend control
// Functional notes
// - trigger mask 0 picks irq10..irq1
// - trigger mask 1 picks irq15..11, bit7 zero
// - trigger mask 1 bit6 picks activity pin
// - trigger mask 1 bit5 picks pci request
// - trigger mask 2 picks io windows, disk
// - trigger mask 2 low bits pick chip selects
// - trigger mask 3 picks eight io windows
// - break mask 0 picks irq10..irq1
// - break mask 1 picks pin, pci, irq15..11
// - break mask 2 picks windows, disk, selects
// - break mask 3 picks eight io windows
// - external smi rising edge, polarity bit inverts
// - enabled external smi plus global bit raises smi
// - software bit zero-to-one raises smi
// - suspend bit7 scales video timer by 16
// - suspend bit6 scales system timer by 16
// - suspend bit5 makes video write break
// - suspend bit4 bypasses video timer
// - suspend bit3 break transition raises smi
// - suspend bit2 enables battery-low suspend entry
// - any enabled trigger restarts standby timer
// - break smi only with break enable
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module sse_event_select (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire sse_pkg::sse_reg_req_t i_reg,
    output logic [7:0] o_reg_rdata,
    // activity pins from the isa/pci side
    input wire sse_pkg::sse_pins_t i_pins,
    // global enables kept in the wider smi control block
    input wire logic i_ext_smi_global_en,
    input wire logic i_sw_smi_global_en,
    input wire logic i_gs_break_smi_en,
    // auto-suspend inputs from same-clock timer logic
    input wire logic i_video_memory_write,
    input wire logic i_as_break_selected,
    input wire logic i_as_sys_expired,
    input wire logic i_as_vm_expired,
    // global standby outputs
    output logic o_gs_timer_restart,
    output logic o_gs_break_event,
    // smi toward the processor
    output logic o_smi,
    output sse_pkg::sse_smi_cause_t o_smi_cause,
    // auto-suspend controls
    output logic o_as_vm_x16,
    output logic o_as_sys_x16,
    output logic o_as_entry,
    output logic o_battery_suspend
);
    import sse_pkg::*;

    logic [7:0] trig_mask [4];
    logic [7:0] brk_mask [4];
    logic [7:0] ext_smi_ctl;
    logic [7:0] sw_smi_ctl;
    logic [7:0] susp_ctl0;
    sse_pins_t pin_s1;
    sse_pins_t pin_s2;
    sse_pins_t pin_s3;
    logic [31:0] activity;
    logic io_access;
    logic [15:0] ioa;
    logic [15:0] irq_rise;
    logic [3:0] gcs_rise;
    logic [2:0] ext_edge;
    logic [2:0] ext_fire;
    logic sw_fire;
    logic trig_hit;
    logic brk_hit;
    logic as_break;
    logic as_break_q;
    logic as_fire;
    logic [7:0] next_rdata;

    // two-stage sync of every pin, third stage only for edge detection
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            // battery-low idles high: no false low after reset
            pin_s1.bat_low_n <= 1'b1;
            pin_s2.bat_low_n <= 1'b1;
            pin_s3.bat_low_n <= 1'b1;
        end else begin
            pin_s1 <= i_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // edges seen on synchronised levels only
    assign irq_rise = pin_s2.irq & ~pin_s3.irq;
    assign gcs_rise = pin_s2.gcs & ~pin_s3.gcs;
    assign ioa = pin_s2.io_addr;
    // a cycle counts once, on the leading edge of its strobe
    assign io_access = (pin_s2.io_rd & ~pin_s3.io_rd) | (pin_s2.io_wr & ~pin_s3.io_wr);

    // activity vector laid out exactly as the four mask registers
    always_comb begin
        activity = '0;
        // byte 0: irq10,9,7,6,5,4,3,1
        activity[7:0] = {irq_rise[10], irq_rise[9], irq_rise[7], irq_rise[6],
                         irq_rise[5], irq_rise[4], irq_rise[3], irq_rise[1]};
        // byte 1: reserved, activity pin, pci request, irq15..11
        activity[14] = pin_s2.ext_act ^ pin_s3.ext_act;
        activity[13] = pin_s2.pci_req & ~pin_s3.pci_req;
        activity[12:8] = irq_rise[15:11];
        // byte 2: 278h, 240h, 220h, disk pair, chip selects 3..0
        activity[23] = io_access & in_window(ioa, IO_278, SPAN_8);
        activity[22] = io_access & in_window(ioa, IO_240, SPAN_16);
        activity[21] = io_access & in_window(ioa, IO_220, SPAN_16);
        activity[20] = io_access & (in_window(ioa, IO_1F0, SPAN_8) |
                                    in_window(ioa, IO_170, SPAN_8));
        activity[19:16] = gcs_rise;
        // byte 3: serial, parallel, sound and network windows
        activity[31] = io_access & in_window(ioa, IO_3F8, SPAN_8);
        activity[30] = io_access & in_window(ioa, IO_3E8, SPAN_8);
        activity[29] = io_access & in_window(ioa, IO_3BC, SPAN_4);
        activity[28] = io_access & in_window(ioa, IO_388, SPAN_4);
        activity[27] = io_access & in_window(ioa, IO_378, SPAN_8);
        activity[26] = io_access & in_window(ioa, IO_300, SPAN_16);
        activity[25] = io_access & in_window(ioa, IO_2F8, SPAN_8);
        activity[24] = io_access & in_window(ioa, IO_2E8, SPAN_8);
    end

    // a clear mask bit blocks its source from its own path only; trigger and break masks are separate
    assign trig_hit = |(activity & {trig_mask[3], trig_mask[2], trig_mask[1], trig_mask[0]});
    assign brk_hit = |(activity & {brk_mask[3], brk_mask[2], brk_mask[1], brk_mask[0]});

    // mask registers; reserved bit 7 of the second of each set never stores
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 4; i++) begin
                trig_mask[i] <= REG_RESET;
                brk_mask[i] <= REG_RESET;
            end
        end else if (i_reg.wr) begin
            unique case (i_reg.addr)
                OFS_TRIG_0: trig_mask[0] <= i_reg.wdata & WMASK_FULL;
                OFS_TRIG_1: trig_mask[1] <= i_reg.wdata & WMASK_SRC_1;
                OFS_TRIG_2: trig_mask[2] <= i_reg.wdata & WMASK_FULL;
                OFS_TRIG_3: trig_mask[3] <= i_reg.wdata & WMASK_FULL;
                OFS_BRK_0: brk_mask[0] <= i_reg.wdata & WMASK_FULL;
                OFS_BRK_1: brk_mask[1] <= i_reg.wdata & WMASK_SRC_1;
                OFS_BRK_2: brk_mask[2] <= i_reg.wdata & WMASK_FULL;
                OFS_BRK_3: brk_mask[3] <= i_reg.wdata & WMASK_FULL;
                default: ;
            endcase
        end
    end

    // smi and suspend control registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ext_smi_ctl <= REG_RESET;
            sw_smi_ctl <= REG_RESET;
            susp_ctl0 <= REG_RESET;
        end else if (i_reg.wr) begin
            unique case (i_reg.addr)
                OFS_EXT_SMI: ext_smi_ctl <= i_reg.wdata & WMASK_EXT_SMI;
                OFS_SW_SMI: sw_smi_ctl <= i_reg.wdata & WMASK_SW_SMI;
                OFS_SUSP_CTL0: susp_ctl0 <= i_reg.wdata & WMASK_FULL;
                default: ;
            endcase
        end
    end

    // software smi: only a write that lifts bit 0 from zero fires
    assign sw_fire = i_reg.wr && (i_reg.addr == OFS_SW_SMI) && i_reg.wdata[SW_SMI_BIT]
                     && !sw_smi_ctl[SW_SMI_BIT] && i_sw_smi_global_en;

    // external smi: polarity picks which edge, enable plus global gate it
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ext_edge[i] = ext_smi_ctl[EXT_POL_LSB + i] ?
                          (~pin_s2.ext_smi[i] & pin_s3.ext_smi[i]) :
                          (pin_s2.ext_smi[i] & ~pin_s3.ext_smi[i]);
            ext_fire[i] = ext_edge[i] & ext_smi_ctl[EXT_EN_LSB + i]
                          & i_ext_smi_global_en;
        end
    end

    // auto-suspend break: selected events plus video write when chosen
    assign as_break = i_as_break_selected | (susp_ctl0[SC_VM_BREAK] & i_video_memory_write);
    assign as_fire = susp_ctl0[SC_BREAK_SMI] & as_break & ~as_break_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            as_break_q <= 1'b0;
        end else begin
            as_break_q <= as_break;
        end
    end

    // standby timer restart and break pulses, one cycle each
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_gs_timer_restart <= 1'b0;
            o_gs_break_event <= 1'b0;
        end else begin
            o_gs_timer_restart <= trig_hit;
            o_gs_break_event <= brk_hit;
        end
    end

    // smi pulse and its cause; break events reach smi only when enabled
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_smi <= 1'b0;
            o_smi_cause <= '0;
        end else begin
            o_smi_cause.ext <= ext_fire;
            o_smi_cause.sw <= sw_fire;
            o_smi_cause.gs_break <= brk_hit & i_gs_break_smi_en;
            o_smi_cause.as_break <= as_fire;
            o_smi <= (|ext_fire) | sw_fire | (brk_hit & i_gs_break_smi_en) | as_fire;
        end
    end

    // auto-suspend controls; the timers themselves live elsewhere
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_as_vm_x16 <= 1'b0;
            o_as_sys_x16 <= 1'b0;
            o_as_entry <= 1'b0;
            o_battery_suspend <= 1'b0;
        end else begin
            o_as_vm_x16 <= susp_ctl0[SC_VM_X16];
            o_as_sys_x16 <= susp_ctl0[SC_SYS_X16];
            o_as_entry <= i_as_sys_expired
                          & (susp_ctl0[SC_VM_BYPASS] | i_as_vm_expired);
            o_battery_suspend <= susp_ctl0[SC_BATLOW] & ~pin_s2.bat_low_n;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (i_reg.addr)
            OFS_TRIG_0: next_rdata = trig_mask[0];
            OFS_TRIG_1: next_rdata = trig_mask[1];
            OFS_TRIG_2: next_rdata = trig_mask[2];
            OFS_TRIG_3: next_rdata = trig_mask[3];
            OFS_BRK_0: next_rdata = brk_mask[0];
            OFS_BRK_1: next_rdata = brk_mask[1];
            OFS_BRK_2: next_rdata = brk_mask[2];
            OFS_BRK_3: next_rdata = brk_mask[3];
            OFS_EXT_SMI: next_rdata = ext_smi_ctl;
            OFS_PIN_STATUS: next_rdata = {3'h0, pin_s2.ext_act, ~pin_s2.bat_low_n,
                                          pin_s2.ext_smi};
            OFS_SW_SMI: next_rdata = sw_smi_ctl;
            OFS_SUSP_CTL0: next_rdata = susp_ctl0;
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg.rd) begin
            o_reg_rdata <= next_rdata;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    irq1_restart_a: assert property (
        (trig_mask[0][0] && irq_rise[1]) |=> o_gs_timer_restart)
        else $error("irq1 activity did not restart standby timer");
    reserved_bit_a: assert property (
        (i_reg.wr && i_reg.addr == OFS_TRIG_1) |=> !trig_mask[1][7])
        else $error("reserved trigger bit stored");
    pin_restart_a: assert property (
        (trig_mask[1][6] && (pin_s2.ext_act != pin_s3.ext_act)) |=> o_gs_timer_restart)
        else $error("activity pin edge did not restart timer");
    disk_restart_a: assert property (
        (trig_mask[2][4] && io_access && (in_window(ioa, IO_170, SPAN_8)
         || in_window(ioa, IO_1F0, SPAN_8))) |=> o_gs_timer_restart)
        else $error("disk access did not restart timer");
    masked_quiet_a: assert property (
        (trig_mask[0] == 8'h00 && trig_mask[1] == 8'h00 && trig_mask[2] == 8'h00
         && trig_mask[3] == 8'h00) |=> !o_gs_timer_restart)
        else $error("restart with all trigger masks clear");
    com1_break_a: assert property (
        (brk_mask[3][7] && io_access && in_window(ioa, IO_3F8, SPAN_8)) |=> o_gs_break_event)
        else $error("serial window access was not a break event");
    ext_fall_a: assert property (
        (ext_smi_ctl[4] && ext_smi_ctl[0] && i_ext_smi_global_en
         && $fell(pin_s2.ext_smi[0])) |=> (o_smi && o_smi_cause.ext[0]))
        else $error("falling external smi edge missed");
    ext_gate_a: assert property (
        !i_ext_smi_global_en |=> !(|o_smi_cause.ext))
        else $error("external smi raised without global enable");
    sw_rise_a: assert property (
        (i_reg.wr && i_reg.addr == OFS_SW_SMI && i_reg.wdata[0] && !sw_smi_ctl[0]
         && i_sw_smi_global_en) |=> (o_smi && o_smi_cause.sw && sw_smi_ctl[0]))
        else $error("software smi not raised on rising bit");
    break_gate_a: assert property (
        o_smi_cause.gs_break |-> ($past(brk_hit) && $past(i_gs_break_smi_en)))
        else $error("break smi without enable");
    bypass_entry_a: assert property (
        (susp_ctl0[4] && i_as_sys_expired) |=> o_as_entry)
        else $error("bypass did not allow entry on system timer");
    as_break_a: assert property (
        (susp_ctl0[3] && $rose(as_break)) |=> o_smi_cause.as_break)
        else $error("suspend break transition gave no smi");
    rdata_one_a: assert property (
        !i_reg.rd |=> o_reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    // trigger path, pci and irq15 from group 1, one source each from groups 2 and 3
    pci_restart_a: assert property (
        (trig_mask[1][5] && pin_s2.pci_req && !pin_s3.pci_req) |=> o_gs_timer_restart)
        else $error("pci request did not restart timer");
    gcs_restart_a: assert property (
        (trig_mask[2][0] && pin_s2.gcs[0] && !pin_s3.gcs[0]) |=> o_gs_timer_restart)
        else $error("chip select 0 did not restart timer");
    window_restart_a: assert property (
        (trig_mask[3][0] && io_access && in_window(ioa, IO_2E8, SPAN_8)) |=> o_gs_timer_restart)
        else $error("io window 2e8 did not restart timer");
    high_irq_restart_a: assert property (
        (trig_mask[1][4] && irq_rise[15]) |=> o_gs_timer_restart)
        else $error("irq15 did not restart timer");
    // break path
    irq10_break_a: assert property (
        (brk_mask[0][7] && irq_rise[10]) |=> o_gs_break_event)
        else $error("irq10 was not a break event");
    pin_break_a: assert property (
        (brk_mask[1][6] && (pin_s2.ext_act != pin_s3.ext_act)) |=> o_gs_break_event)
        else $error("activity pin was not a break event");
    gcs_break_a: assert property (
        (brk_mask[2][3] && pin_s2.gcs[3] && !pin_s3.gcs[3]) |=> o_gs_break_event)
        else $error("chip select 3 was not a break event");
    // smi and auto-suspend
    ext_rise_a: assert property (
        (!ext_smi_ctl[5] && ext_smi_ctl[1] && i_ext_smi_global_en
         && $rose(pin_s2.ext_smi[1])) |=> (o_smi && o_smi_cause.ext[1]))
        else $error("rising external smi edge missed");
    vm_scale_a: assert property (
        o_as_vm_x16 == $past(susp_ctl0[SC_VM_X16]))
        else $error("video timer scale off");
    sys_scale_a: assert property (
        o_as_sys_x16 == $past(susp_ctl0[SC_SYS_X16]))
        else $error("system timer scale off");
    vm_break_a: assert property (
        (susp_ctl0[3] && susp_ctl0[5] && i_video_memory_write && !as_break_q)
        |=> o_smi_cause.as_break)
        else $error("video write gave no break smi");
    battery_entry_a: assert property (
        (susp_ctl0[2] && !pin_s2.bat_low_n) |=> o_battery_suspend)
        else $error("battery low did not request suspend");

    sw_smi_c: cover property (i_reg.wr && i_reg.addr == OFS_SW_SMI ##1 o_smi);
    restart_c: cover property (o_gs_timer_restart ##[1:20] o_gs_break_event);
    ext_smi_c: cover property (o_smi && o_smi_cause.ext != 3'h0);
    entry_c: cover property ($rose(o_as_entry));
endmodule

// ==== verif/sse_pin_partner.sv ====
// isa/pci activity and outside smi pin driver standing in for the far side
`timescale 1ns/1ps
module sse_pin_partner (
    // clock
    input wire logic i_mclk,
    // pins toward the selector
    output sse_pkg::sse_pins_t o_pins
);
    import sse_pkg::*;
    localparam int IRQ_LO [8] = '{1, 3, 4, 5, 6, 7, 9, 10};
    localparam logic [15:0] IO_HI [8] = '{IO_2E8, IO_2F8, IO_300, IO_378,
        IO_388, IO_3BC, IO_3E8, IO_3F8};

    // idle bus: no strobes, battery fine, address outside every window
    initial begin
        o_pins = '0;
        o_pins.bat_low_n = 1'b1;
        o_pins.io_addr = 16'h0080;
    end

    // one burst of activity on source bit b of mask group k
    task automatic activity(input int k, input int b, input logic [15:0] off,
                            input logic use_wr);
        logic [15:0] a;
        a = 16'h0000;
        if (k == 3) a = IO_HI[b] + (off & ((b == 4 || b == 5) ? 16'h0003 : 16'h0007));
        if (k == 2 && b >= 4) begin
            a = (b == 5) ? IO_220 : (b == 6) ? IO_240 : IO_278;
            if (b == 4) a = off[8] ? IO_170 : IO_1F0;
            a = a + (off & 16'h0007);
        end
        @(posedge i_mclk);
        if (a != 16'h0000) begin
            // address settles a cycle before the strobe rises
            o_pins.io_addr <= a;
            @(posedge i_mclk);
            if (use_wr) o_pins.io_wr <= 1'b1;
            else o_pins.io_rd <= 1'b1;
        end else if (k == 0) o_pins.irq[IRQ_LO[b]] <= 1'b1;
        else if (k == 2) o_pins.gcs[b] <= 1'b1;
        else if (b < 5) o_pins.irq[11 + b] <= 1'b1;
        else if (b == 5) o_pins.pci_req <= 1'b1;
        else o_pins.ext_act <= ~o_pins.ext_act; // single toggle: either edge counts
        repeat (3) @(posedge i_mclk);
        o_pins.irq <= '0;
        o_pins.pci_req <= 1'b0;
        o_pins.gcs <= '0;
        o_pins.io_rd <= 1'b0;
        o_pins.io_wr <= 1'b0;
        // released bus must not keep showing the old address
        @(posedge i_mclk);
        o_pins.io_addr <= ~o_pins.io_addr;
    endtask

    // level pins: outside smi inputs and battery-low
    task automatic misc(input logic [2:0] smi, input logic bat_n);
        @(posedge i_mclk);
        o_pins.ext_smi <= smi;
        o_pins.bat_low_n <= bat_n;
    endtask
endmodule

// ==== verif/sse_event_select_tb.sv ====
// self-checking bench for the standby/suspend event selector
`timescale 1ns/1ps
module sse_event_select_tb;
    import sse_pkg::*;
    logic i_mclk;
    logic i_rst;
    sse_reg_req_t req;
    sse_pins_t pins;
    logic ext_gl, sw_gl, brk_en, vmw, asb, sys_exp, vm_exp;
    logic [7:0] rdata;
    logic rst_p, brk_p, smi, vm16, sys16, entry, bsusp;
    sse_smi_cause_t cause, last_cause;
    logic [7:0] mdl [256] = '{default: 8'h00};
    int n_rst = 0, n_brk = 0, n_smi = 0, fail_count = 0, comparisons = 0, seed = 46827;
    localparam logic [7:0] TRIG [4] = '{OFS_TRIG_0, OFS_TRIG_1, OFS_TRIG_2, OFS_TRIG_3};
    localparam logic [7:0] BRK [4] = '{OFS_BRK_0, OFS_BRK_1, OFS_BRK_2, OFS_BRK_3};
    localparam logic [7:0] ALL [12] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h38,
        8'h39, 8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h36};

    // 4 ns clock
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    sse_event_select dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_reg(req), .o_reg_rdata(rdata), .i_pins(pins),
        .i_ext_smi_global_en(ext_gl), .i_sw_smi_global_en(sw_gl),
        .i_gs_break_smi_en(brk_en), .i_video_memory_write(vmw),
        .i_as_break_selected(asb), .i_as_sys_expired(sys_exp), .i_as_vm_expired(vm_exp),
        .o_gs_timer_restart(rst_p), .o_gs_break_event(brk_p), .o_smi(smi),
        .o_smi_cause(cause), .o_as_vm_x16(vm16), .o_as_sys_x16(sys16),
        .o_as_entry(entry), .o_battery_suspend(bsusp)
    );
    sse_pin_partner bus_u (.i_mclk(i_mclk), .o_pins(pins));

    // pulse tallies; outputs are idle whenever the main sequence snapshots them
    always @(posedge i_mclk) begin
        n_rst += (rst_p === 1'b1);
        n_brk += (brk_p === 1'b1);
        n_smi += (smi === 1'b1);
        if (smi === 1'b1) last_cause = cause;
    end

    // writable bits per offset; unmapped places keep nothing
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h33, 8'h38: wmask = 8'h7f;
            8'h3c: wmask = 8'h77;
            8'h3e: wmask = 8'h01;
            8'h32, 8'h34, 8'h35, 8'h37, 8'h39, 8'h3a, 8'h40: wmask = 8'hff;
            default: wmask = 8'h00;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge i_mclk);
        req.wr <= 1'b0;
        mdl[a] = d & wmask(a);
    endtask

    task automatic rd_chk(input logic [7:0] a);
        @(posedge i_mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge i_mclk);
        req.rd <= 1'b0;
        #1;
        check("rdata", 32'(rdata), 32'(mdl[a]));
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog: the full sequence needs a few thousand cycles
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        stop_test();
    end

    initial begin
        int k, b, p, j, md, e, r0, b0, s0;
        logic [7:0] d;
        logic g;
        logic [4:0] w;
        i_rst = 1'b1;
        req = '0;
        {ext_gl, sw_gl, brk_en, vmw, asb, sys_exp, vm_exp} = '0;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        // reset values, then random data through the byte masks
        foreach (ALL[i]) rd_chk(ALL[i]);
        foreach (ALL[i]) begin
            wr(ALL[i], 8'($random(seed)));
            rd_chk(ALL[i]);
        end
        foreach (ALL[i]) wr(ALL[i], 8'h00);
        // each source alone selected, then every bit but its own
        for (k = 0; k < 4; k++) for (b = 0; b < 8; b++) for (p = 0; p < 2; p++) begin
            if (k == 1 && b == 7) continue;
            d = p ? ~(8'h01 << b) : (8'h01 << b);
            wr(TRIG[k], d);
            wr(BRK[k], d);
            brk_en <= 1'($random(seed));
            r0 = n_rst;
            b0 = n_brk;
            s0 = n_smi;
            bus_u.activity(k, b, 16'($random(seed)), 1'($random(seed)));
            repeat (8) @(posedge i_mclk);
            check("restart", n_rst - r0, 1 - p);
            check("break", n_brk - b0, 1 - p);
            check("gs smi", n_smi - s0, (1 - p) & brk_en);
            if (p == 0 && brk_en) check("cause", last_cause, 6'b000010);
            wr(TRIG[k], 8'h00);
            wr(BRK[k], 8'h00);
        end
        // outside smi: off globally, on, pin not enabled; both polarities
        for (j = 0; j < 3; j++) for (p = 0; p < 2; p++) for (md = 0; md < 3; md++) begin
            wr(OFS_EXT_SMI, 8'(int'(md != 2) << j) | 8'(p << (4 + j)));
            ext_gl <= (md != 0);
            for (e = 1; e >= 0; e--) begin
                s0 = n_smi;
                bus_u.misc(3'(e << j), 1'b1);
                repeat (6) @(posedge i_mclk);
                check("ext smi", n_smi - s0, (md == 1) && (e == 1 - p));
                if (md == 1 && e == 1 - p) check("cause", last_cause, {3'(1 << j), 3'b000});
            end
        end
        // software smi: only a zero-to-one change of the stored bit counts
        for (j = 0; j < 16; j++) begin
            d = 8'($random(seed));
            g = 1'($random(seed));
            e = g & d[0] & ~mdl[OFS_SW_SMI][0];
            sw_gl <= g;
            s0 = n_smi;
            wr(OFS_SW_SMI, d);
            repeat (3) @(posedge i_mclk);
            check("sw smi", n_smi - s0, e);
            if (e) check("cause", last_cause, 6'b000100);
            rd_chk(OFS_SW_SMI);
        end
        // suspend control levels and the auto-suspend break smi
        for (j = 0; j < 24; j++) begin
            d = 8'($random(seed));
            w = 5'($random(seed));
            wr(OFS_SUSP_CTL0, d);
            sys_exp <= w[0];
            vm_exp <= w[1];
            bus_u.misc(3'b000, ~w[2]);
            repeat (6) @(posedge i_mclk);
            check("vm x16", vm16, d[7]);
            check("sys x16", sys16, d[6]);
            check("entry", entry, w[0] & (d[4] | w[1]));
            check("battery", bsusp, d[2] & w[2]);
            mdl[OFS_PIN_STATUS] = {4'h0, w[2], 3'h0};
            rd_chk(OFS_PIN_STATUS);
            s0 = n_smi;
            e = d[3] & (w[3] | (d[5] & w[4]));
            asb <= w[3];
            vmw <= w[4];
            @(posedge i_mclk);
            vmw <= 1'b0;
            repeat (3) @(posedge i_mclk);
            asb <= 1'b0;
            repeat (4) @(posedge i_mclk);
            check("as smi", n_smi - s0, e);
            if (e) check("cause", last_cause, 6'b000001);
        end
        stop_test();
    end
endmodule
